// ### eps_map.svh
// Constants for the word programming sequencer.
// Operation
// [R1] Program pulse is one 100 us low strobe.
// [R2] Start at address zero with programming supplies.
// [R3] First pass: one pulse per word, no verify.
// [R4] Then verify and reprogram from address zero.
// [R5] On mismatch, up to 10 pulses, verify each.
// [R6] Still wrong after 10 pulses: part failed.
// [R7] Verified word advances address until all checked.
// [R8] Lower supplies, re-read all, declare result.
// [R9] Identification word: upper byte zero, selected by line.
// [R10] Core supply on first, off last.
// [R11] Identification: strobes low, id line high voltage; the code holds program_strobe_n high, only chip_sel_n and out_en_n go low.
// [R12] Pulse drives data; verify lets device drive.
`ifndef EPS_MAP_SVH
`define EPS_MAP_SVH
`define EPS_CLK_MHZ 200
`define EPS_PULSE_US 100
`define EPS_PULSE_CYC (`EPS_PULSE_US * `EPS_CLK_MHZ)
`define EPS_SETUP_US 2
`define EPS_SETUP_CYC (`EPS_SETUP_US * `EPS_CLK_MHZ)
`define EPS_READ_NS 150
`define EPS_READ_CYC ((`EPS_READ_NS * `EPS_CLK_MHZ + 999) / 1000)
`define EPS_MAX_RETRY 10
`endif

// ### eps_pkg.sv
// Types for the word programming sequencer.
package eps_pkg;
  typedef enum logic [3:0] {
    EPS_IDLE = 4'h0,
    EPS_VCC_UP = 4'h1,
    EPS_VPP_UP = 4'h2,
    EPS_P1_SET = 4'h3,
    EPS_P1_PULSE = 4'h4,
    EPS_VF_SET = 4'h5,
    EPS_VF_READ = 4'h6,
    EPS_VF_PULSE = 4'h7,
    EPS_VPP_DN = 4'h8,
    EPS_VCC_DN = 4'h9,
    EPS_FR_READ = 4'hA,
    EPS_ID_READ = 4'hB,
    EPS_DONE = 4'hC
  } eps_state_t;
endpackage

// ### eps_tmr_if.sv
// Timer request and expiry signals between sequencer and timer.
`timescale 1ns/1ps
interface eps_tmr_if #(parameter int CW = 16);
  logic load;
  logic [CW-1:0] count;
  logic expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface

// ### eps_timer.sv
// Down counter that times pulses, setups and read access.
`timescale 1ns/1ps
module eps_timer #(parameter int CW = 16) (
  input wire logic core_clk,
  input wire logic rstn,
  eps_tmr_if.tmr t
);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_exp;
  logic exp_q;
  assign t.expired = exp_q;
  always_comb begin
    next_cnt = cnt;
    next_exp = 1'b0;
    if (t.load) begin
      next_cnt = t.count;
    end else if (cnt != '0) begin
      next_cnt = cnt - 1'b1;
      next_exp = (cnt == {{(CW-1){1'b0}}, 1'b1});
    end
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt <= next_cnt;
      exp_q <= next_exp;
    end
  end
endmodule

// ### eps_programmer.sv
// Programmer that drives the one-time memory through its pins.
`timescale 1ns/1ps
`include "eps_map.svh"
module eps_programmer #(
  parameter int AW = 16,
  parameter int DW = 16,
  parameter int PULSE_CYC = `EPS_PULSE_CYC,
  parameter int SETUP_CYC = `EPS_SETUP_CYC,
  parameter int READ_CYC = `EPS_READ_CYC,
  parameter int MAX_RETRY = `EPS_MAX_RETRY
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic id_start,
  input wire logic id_sel,
  input wire logic [AW-1:0] last_addr,
  input wire logic [DW-1:0] src_data,
  input wire logic [DW-1:0] dev_data_in,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] dev_data_out,
  output logic dev_data_oe,
  output logic chip_sel_n,
  output logic out_en_n,
  output logic program_strobe_n,
  output logic vcc_prog,
  output logic vpp_prog,
  output logic id_mode_line,
  output logic busy,
  output logic done,
  output logic pass,
  output logic [DW-1:0] id_word
);
  localparam int CW = 16;
  eps_tmr_if #(.CW(CW)) tif ();
  eps_timer #(.CW(CW)) u_tmr (.core_clk(core_clk), .rstn(rstn), .t(tif));
  eps_pkg::eps_state_t st, next_st;
  logic [AW-1:0] next_addr;
  logic [DW-1:0] next_dout, next_idw;
  logic next_oe, next_cs_n, next_oe_n, next_pgm_n, next_vcc, next_vpp, next_idl;
  logic next_busy, next_done, next_pass;
  logic [3:0] retry, next_retry;
  logic fail, next_fail;
  logic ld;
  logic [CW-1:0] ldc;
  assign tif.load = ld;
  assign tif.count = ldc;
  always_comb begin
    next_st = st;
    next_addr = addr;
    next_dout = dev_data_out;
    next_idw = id_word;
    next_oe = dev_data_oe;
    next_cs_n = chip_sel_n;
    next_oe_n = out_en_n;
    next_pgm_n = program_strobe_n;
    next_vcc = vcc_prog;
    next_vpp = vpp_prog;
    next_idl = id_mode_line;
    next_busy = busy;
    next_done = done;
    next_pass = pass;
    next_retry = retry;
    next_fail = fail;
    ld = 1'b0;
    ldc = CW'(SETUP_CYC);
    case (st)
      eps_pkg::EPS_IDLE: begin
        if (start) begin
          next_busy = 1'b1;
          next_done = 1'b0;
          next_pass = 1'b0;
          next_fail = 1'b0;
          next_addr = '0; // [R2]
          next_vcc = 1'b1; // [R10]
          ld = 1'b1;
          next_st = eps_pkg::EPS_VCC_UP;
        end else if (id_start) begin
          next_busy = 1'b1;
          next_done = 1'b0;
          next_addr = {{(AW-1){1'b0}}, id_sel}; // [R11]
          next_idl = 1'b1; // [R11]
          next_cs_n = 1'b0;
          next_oe_n = 1'b0;
          ld = 1'b1;
          ldc = CW'(SETUP_CYC);
          next_st = eps_pkg::EPS_ID_READ;
        end
      end
      eps_pkg::EPS_VCC_UP: begin
        if (tif.expired) begin
          next_vpp = 1'b1; // [R10]
          ld = 1'b1;
          next_st = eps_pkg::EPS_VPP_UP;
        end
      end
      eps_pkg::EPS_VPP_UP: begin
        if (tif.expired) begin
          next_cs_n = 1'b0; // [R12]
          next_oe_n = 1'b1;
          next_dout = src_data;
          next_oe = 1'b1;
          ld = 1'b1;
          next_st = eps_pkg::EPS_P1_SET; // [R2]
        end
      end
      eps_pkg::EPS_P1_SET: begin
        // Data follows the new address one cycle late, well inside the setup wait.
        next_dout = src_data; // [R12]
        if (tif.expired) begin
          next_pgm_n = 1'b0; // [R1]
          ld = 1'b1;
          ldc = CW'(PULSE_CYC);
          next_st = eps_pkg::EPS_P1_PULSE;
        end
      end
      eps_pkg::EPS_P1_PULSE: begin
        if (tif.expired) begin
          next_pgm_n = 1'b1; // [R1]
          ld = 1'b1;
          if (addr == last_addr) begin
            next_addr = '0; // [R4]
            next_oe = 1'b0;
            next_retry = '0;
            next_st = eps_pkg::EPS_VF_SET;
          end else begin
            next_addr = addr + 1'b1; // [R3]
            next_st = eps_pkg::EPS_P1_SET;
          end
        end
      end
      eps_pkg::EPS_VF_SET: begin
        if (tif.expired) begin
          next_oe_n = 1'b0; // [R12]
          ld = 1'b1;
          ldc = CW'(READ_CYC);
          next_st = eps_pkg::EPS_VF_READ;
        end
      end
      eps_pkg::EPS_VF_READ: begin
        if (tif.expired) begin
          next_oe_n = 1'b1;
          ld = 1'b1;
          if (dev_data_in == src_data) begin
            next_retry = '0;
            if (addr == last_addr) begin
              next_vpp = 1'b0; // [R8]
              next_st = eps_pkg::EPS_VPP_DN;
            end else begin
              next_addr = addr + 1'b1; // [R7]
              next_st = eps_pkg::EPS_VF_SET;
            end
          end else if (retry == 4'(MAX_RETRY)) begin
            next_fail = 1'b1; // [R6]
            next_vpp = 1'b0;
            next_st = eps_pkg::EPS_VPP_DN;
          end else begin
            next_retry = retry + 4'h1; // [R5]
            next_dout = src_data;
            next_oe = 1'b1;
            next_st = eps_pkg::EPS_VF_PULSE;
          end
        end
      end
      eps_pkg::EPS_VF_PULSE: begin
        // A pulse is preceded by one setup wait with output enable high.
        if (tif.expired && program_strobe_n) begin
          next_pgm_n = 1'b0; // [R5]
          ld = 1'b1;
          ldc = CW'(PULSE_CYC);
        end else if (tif.expired) begin
          next_pgm_n = 1'b1;
          next_oe = 1'b0;
          ld = 1'b1;
          next_st = eps_pkg::EPS_VF_SET;
        end
      end
      eps_pkg::EPS_VPP_DN: begin
        if (tif.expired) begin
          next_vcc = 1'b0; // [R10]
          ld = 1'b1;
          next_st = eps_pkg::EPS_VCC_DN;
        end
      end
      eps_pkg::EPS_VCC_DN: begin
        if (tif.expired) begin
          if (fail) begin
            next_cs_n = 1'b1;
            next_busy = 1'b0;
            next_done = 1'b1;
            next_pass = 1'b0; // [R6]
            next_st = eps_pkg::EPS_DONE;
          end else begin
            next_addr = '0; // [R8]
            next_oe_n = 1'b0;
            ld = 1'b1;
            ldc = CW'(READ_CYC);
            next_pass = 1'b1;
            next_st = eps_pkg::EPS_FR_READ;
          end
        end
      end
      eps_pkg::EPS_FR_READ: begin
        if (tif.expired) begin
          ld = 1'b1;
          ldc = CW'(READ_CYC);
          if (dev_data_in != src_data) begin
            next_pass = 1'b0; // [R8]
          end
          if (addr == last_addr) begin
            next_oe_n = 1'b1;
            next_cs_n = 1'b1;
            next_busy = 1'b0;
            next_done = 1'b1;
            ld = 1'b0;
            next_st = eps_pkg::EPS_DONE;
          end else begin
            next_addr = addr + 1'b1;
          end
        end
      end
      eps_pkg::EPS_ID_READ: begin
        if (tif.expired) begin
          // The device clears the upper byte; it is masked here as well.
          next_idw = {8'h00, dev_data_in[7:0]}; // [R9]
          next_idl = 1'b0;
          next_oe_n = 1'b1;
          next_cs_n = 1'b1;
          next_busy = 1'b0;
          next_done = 1'b1;
          next_st = eps_pkg::EPS_DONE;
        end
      end
      eps_pkg::EPS_DONE: begin
        next_done = 1'b0;
        next_st = eps_pkg::EPS_IDLE;
      end
      default: begin
        next_st = eps_pkg::EPS_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= eps_pkg::EPS_IDLE;
      addr <= '0;
      dev_data_out <= '0;
      id_word <= '0;
      dev_data_oe <= 1'b0;
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      program_strobe_n <= 1'b1;
      vcc_prog <= 1'b0;
      vpp_prog <= 1'b0;
      id_mode_line <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      retry <= 4'h0;
      fail <= 1'b0;
    end else begin
      st <= next_st;
      addr <= next_addr;
      dev_data_out <= next_dout;
      id_word <= next_idw;
      dev_data_oe <= next_oe;
      chip_sel_n <= next_cs_n;
      out_en_n <= next_oe_n;
      program_strobe_n <= next_pgm_n;
      vcc_prog <= next_vcc;
      vpp_prog <= next_vpp;
      id_mode_line <= next_idl;
      busy <= next_busy;
      done <= next_done;
      pass <= next_pass;
      retry <= next_retry;
      fail <= next_fail;
    end
  end
endmodule

// ### eps_checker.sv
// Pin-level assertions for the word programming sequencer.
`timescale 1ns/1ps
module eps_checker #(
  parameter int AW = 16,
  parameter int DW = 16,
  parameter int PULSE_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic id_start,
  input wire logic id_sel,
  input wire logic [AW-1:0] addr,
  input wire logic dev_data_oe,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic program_strobe_n,
  input wire logic vcc_prog,
  input wire logic vpp_prog,
  input wire logic id_mode_line,
  input wire logic busy,
  input wire logic done,
  input wire logic [DW-1:0] id_word
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] low_len;
  logic [15:0] next_low_len;
  always_comb begin
    next_low_len = program_strobe_n ? 16'h0000 : low_len + 16'h0001;
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      low_len <= 16'h0000;
    end else begin
      low_len <= next_low_len;
    end
  end
  sequence s_id_req;
    id_start && !start && !busy && !done && !$past(done);
  endsequence
  property p_supply_order; vpp_prog |-> vcc_prog; endproperty
  a_supply_order: assert property (p_supply_order) else $error("supply order broken");
  property p_pulse_pins; !program_strobe_n |-> !chip_sel_n && out_en_n && dev_data_oe && vpp_prog;
  endproperty
  a_pulse_pins: assert property (p_pulse_pins) else $error("pins wrong in pulse");
  property p_verify_pins; !out_en_n |-> program_strobe_n && !dev_data_oe; endproperty
  a_verify_pins: assert property (p_verify_pins) else $error("pins wrong in read");
  property p_pulse_width; $rose(program_strobe_n) |-> low_len == PULSE_CYC + 1; endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("pulse width wrong");
  property p_id_pins;
    id_mode_line |-> !chip_sel_n && !out_en_n && addr[AW-1:1] == '0 && !vpp_prog;
  endproperty
  a_id_pins: assert property (p_id_pins) else $error("id pins wrong");
  property p_id_upper; id_word[DW-1:8] == '0; endproperty
  a_id_upper: assert property (p_id_upper) else $error("id upper byte set");
  property p_id_sel; s_id_req |=> id_mode_line && addr[0] == $past(id_sel); endproperty
  a_id_sel: assert property (p_id_sel) else $error("id select wrong");
  property p_final_read; !out_en_n && !vpp_prog |-> !vcc_prog; endproperty
  a_final_read: assert property (p_final_read) else $error("re-read at high supply");
  property p_done_once; done |=> !done && !busy; endproperty
  a_done_once: assert property (p_done_once) else $error("done not single");
endmodule
bind eps_programmer eps_checker #(.AW(AW), .DW(DW), .PULSE_CYC(PULSE_CYC)) u_eps_checker (
  .core_clk(core_clk), .rstn(rstn), .start(start), .id_start(id_start), .id_sel(id_sel),
  .addr(addr), .dev_data_oe(dev_data_oe), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
  .program_strobe_n(program_strobe_n), .vcc_prog(vcc_prog), .vpp_prog(vpp_prog),
  .id_mode_line(id_mode_line), .busy(busy), .done(done), .id_word(id_word));

// ### eps_dev_model.sv
// Behavioural one-time memory answering the programmer's pins.
`timescale 1ns/1ps
module eps_dev_model #(
  parameter logic [15:0] MAKER_WORD = 16'h0055, // Arbitrary code.
  parameter logic [15:0] PART_WORD = 16'h00AA // Arbitrary code.
) (
  input wire logic [3:0] addr,
  input wire logic [15:0] dev_data_out,
  input wire logic dev_data_oe,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic program_strobe_n,
  input wire logic vcc_prog,
  input wire logic vpp_prog,
  input wire logic id_mode_line,
  input wire logic erase,
  input wire logic [3:0] hard_addr,
  input wire logic [4:0] hard_need,
  output logic [15:0] dev_data_in
);
  logic [15:0] mem [16];
  int hits [16];
  logic drv;
  logic [15:0] val;
  logic [15:0] held;
  always @(posedge erase) begin
    foreach (mem[i]) begin
      mem[i] = 16'hFFFF;
      hits[i] = 0;
    end
  end
  // A stubborn word keeps its erased value until it has seen enough pulses.
  // Pins are taken as the pulse begins, since address and data move as it ends.
  always @(negedge program_strobe_n) begin
    if (!chip_sel_n && out_en_n && dev_data_oe && vcc_prog && vpp_prog) begin
      hits[addr] = hits[addr] + 1;
      if (addr != hard_addr || hits[addr] >= int'(hard_need)) begin
        mem[addr] = mem[addr] & dev_data_out;
      end
    end
  end
  assign drv = !chip_sel_n && !out_en_n && program_strobe_n;
  assign val = id_mode_line ? (addr[0] ? PART_WORD : MAKER_WORD) : mem[addr];
  always @(val or drv) begin
    if (drv) begin
      held = val;
    end
  end
  // Released lines show the inverse so a stale sample cannot pass.
  assign dev_data_in = drv ? val : ~held;
endmodule

// ### eps_programmer_tb_top.sv
// Self-checking testbench for the word programming sequencer.
`timescale 1ns/1ps
module eps_programmer_tb_top;
  localparam logic [15:0] MAKER = 16'h0055; // Arbitrary code.
  localparam logic [15:0] PART = 16'h00AA; // Arbitrary code.
  logic core_clk, rstn, start, id_start, id_sel, erase;
  logic [3:0] addr, hard_addr, last_addr;
  logic [4:0] hard_need;
  logic [15:0] src_data, dev_data_in, dev_data_out, id_word, pin_word;
  logic dev_data_oe, chip_sel_n, out_en_n, program_strobe_n, vcc_prog, vpp_prog;
  logic id_mode_line, busy, done, pass;
  logic [15:0] src_mem [4] = '{16'h1234, 16'hA5C3, 16'h0F0F, 16'h7E81};
  logic [15:0] pulses [16];
  int miscompares = 0;
  int checks_done = 0;
  assign src_data = src_mem[addr[1:0]];
  assign pin_word = {10'h0, busy, vcc_prog, vpp_prog, chip_sel_n, out_en_n, program_strobe_n};
  eps_programmer #(.AW(4), .DW(16), .PULSE_CYC(20), .SETUP_CYC(4), .READ_CYC(2)) u_eps_programmer (
    .core_clk(core_clk), .rstn(rstn), .start(start), .id_start(id_start), .id_sel(id_sel),
    .last_addr(last_addr), .src_data(src_data), .dev_data_in(dev_data_in), .addr(addr),
    .dev_data_out(dev_data_out), .dev_data_oe(dev_data_oe), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .program_strobe_n(program_strobe_n), .vcc_prog(vcc_prog),
    .vpp_prog(vpp_prog), .id_mode_line(id_mode_line), .busy(busy), .done(done),
    .pass(pass), .id_word(id_word));
  eps_dev_model #(.MAKER_WORD(MAKER), .PART_WORD(PART)) u_eps_dev_model (
    .addr(addr), .dev_data_out(dev_data_out), .dev_data_oe(dev_data_oe),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .program_strobe_n(program_strobe_n),
    .vcc_prog(vcc_prog), .vpp_prog(vpp_prog), .id_mode_line(id_mode_line), .erase(erase),
    .hard_addr(hard_addr), .hard_need(hard_need), .dev_data_in(dev_data_in));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(negedge program_strobe_n) begin
    pulses[addr] = pulses[addr] + 16'h0001;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // The two extra idle cycles keep the next request clear of the done cycle.
  task automatic wait_done();
    int n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge core_clk);
      n++;
    end
    chk("done", 16'h0001, {15'h0, done});
    repeat (2) @(negedge core_clk);
  endtask
  task automatic run_prog(input logic [4:0] need, input logic exp_pass);
    logic [15:0] exp_n;
    erase = 1'b1;
    hard_need = need;
    foreach (pulses[i]) pulses[i] = 16'h0000;
    @(negedge core_clk);
    erase = 1'b0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (50) @(negedge core_clk);
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    wait_done();
    chk("pass", {15'h0, exp_pass}, {15'h0, pass});
    for (int i = 0; i < 4; i++) begin
      exp_n = (i == 2) ? ((need > 5'h0B) ? 16'h000B : {11'h0, need}) : 16'h0001;
      chk("pulses", exp_n, pulses[i]);
    end
  endtask
  // A reset in mid-pulse must drop both supplies and release every strobe.
  task automatic run_reset();
    erase = 1'b1;
    @(negedge core_clk);
    erase = 1'b0;
    start = 1'b1;
    @(negedge core_clk);
    start = 1'b0;
    repeat (30) @(negedge core_clk);
    chk("strobe before reset", 16'h0000, {15'h0, program_strobe_n});
    rstn = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("pins in reset", 16'h0007, pin_word);
    rstn = 1'b1;
    @(negedge core_clk);
    chk("pins after reset", 16'h0007, pin_word);
  endtask
  task automatic run_id(input logic sel, input logic [15:0] exp);
    id_sel = sel;
    id_start = 1'b1;
    @(negedge core_clk);
    id_start = 1'b0;
    wait_done();
    chk("id_word", exp, id_word);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    {start, id_start, id_sel, erase} = 4'h0;
    hard_addr = 4'h2;
    hard_need = 5'h01;
    last_addr = 4'h3;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    run_prog(5'h04, 1'b1);
    run_prog(5'h0B, 1'b1);
    run_prog(5'h0C, 1'b0);
    run_reset();
    run_id(1'b0, MAKER);
    run_id(1'b1, PART);
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    print_verdict();
  end
endmodule
